// *** core/cse_regs.sv ***
`default_nettype none

module cse_regs
    import cse_pkg::*;
(
    // clock, reset, enable
    input  wire logic        CORE_CLK,
    input  wire logic        RESET,
    input  wire logic        CLK_EN,
    // two-wire serial pins
    input  wire logic        SCL_IN,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE,
    // analog comparators and pins, asynchronous
    input  wire logic        INPUT_OVERVOLT_CMP,
    input  wire logic        INPUT_SAG_CMP,
    input  wire logic        INPUT_UNDERVOLT_CMP,
    input  wire logic        BATTERY_OVERVOLT_CMP,
    input  wire logic        BATTERY_UNDERVOLT_CMP,
    input  wire logic        THERMAL_CRITICAL_CMP,
    input  wire logic        THERMAL_WARNING_CMP,
    input  wire logic        PEAK_CURRENT_CMP,
    input  wire logic        ENABLE_PIN,
    input  wire logic        IO_SUPPLY_LOW,
    // mode controller, same clock
    input  wire logic        MODE_ACTIVE,
    input  wire logic        ENABLE_REQUEST,
    input  wire logic        TIMER_EXPIRED,
    input  wire logic        THERMAL_RESET_ENTRY,
    input  wire logic        POWER_ON_ENTRY,
    input  wire logic        READY_ENTRY,
    // outputs
    output logic             IRQ,
    output logic             EN_BLOCKED,
    output logic [15:0]      SAG_THRESHOLD_MV,
    output logic [15:0]      BAT_LOW_THRESHOLD_MV,
    output logic [15:0]      BAT_HIGH_THRESHOLD_MV
);
    import cse_pkg::*;

    function automatic logic [15:0] sag_mv(input logic [7:0] code);
        int n;
        int mv;
        n = int'((code > SAG_CODE_MAX) ? SAG_CODE_MAX : code);
        if (n <= 'h0E) begin
            mv = 4300 + n * 50;
        end else if (n <= 'h1D) begin
            mv = 5000 + (n - 'h0E) * 200;
        end else if (n <= 'h27) begin
            mv = 8000 + (n - 'h1D) * 100;
        end else if (n <= 'h31) begin
            mv = 9000 + (n - 'h27) * 200;
        end else begin
            mv = 11000 + (n - 'h31) * 100;
        end
        return 16'(mv);
    endfunction

    function automatic logic [15:0] bat_mv(input int base, input logic [7:0] code);
        return 16'(base + int'(code[BAT_CODE_W-1:0]) * BAT_STEP_MV);
    endfunction

    // ---------------- input synchronisers ----------------
    logic [AI_COUNT-1:0] async_in;
    logic [AI_COUNT-1:0] sync1_reg;
    logic [AI_COUNT-1:0] sync2_reg;
    logic [AI_COUNT-1:0] sync3_reg;
    logic [AI_COUNT-1:0] filt_reg;

    assign async_in = {SDA_IN, SCL_IN, IO_SUPPLY_LOW, ENABLE_PIN, PEAK_CURRENT_CMP,
                       THERMAL_WARNING_CMP, THERMAL_CRITICAL_CMP, BATTERY_UNDERVOLT_CMP,
                       BATTERY_OVERVOLT_CMP, INPUT_UNDERVOLT_CMP, INPUT_SAG_CMP,
                       INPUT_OVERVOLT_CMP};

    for (genvar i = 0; i < AI_COUNT; i++) begin : g_sync
        always_ff @(posedge CORE_CLK or posedge RESET) begin
            if (RESET) begin
                sync1_reg[i] <= SYNC_RST[i];
                sync2_reg[i] <= SYNC_RST[i];
                sync3_reg[i] <= SYNC_RST[i];
                filt_reg[i]  <= SYNC_RST[i];
            end else if (CLK_EN) begin
                sync1_reg[i] <= async_in[i];
                sync2_reg[i] <= sync1_reg[i];
                sync3_reg[i] <= sync2_reg[i];
                // a change counts only once two stages agree
                if (sync2_reg[i] == sync3_reg[i]) begin
                    filt_reg[i] <= sync3_reg[i];
                end
            end
        end
    end

    logic io_low;
    assign io_low = filt_reg[AI_IO_LOW];

    // ---------------- peak current debounce ----------------
    logic [DEB_W-1:0] deb_cnt_reg;
    logic             peak_db_reg;

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            deb_cnt_reg <= '0;
            peak_db_reg <= 1'b0;
        end else if (CLK_EN) begin
            if (filt_reg[AI_PEAK] == peak_db_reg) begin
                deb_cnt_reg <= '0;
            end else if (deb_cnt_reg == DEB_W'(DEBOUNCE_CYCLES - 1)) begin
                deb_cnt_reg <= '0;
                peak_db_reg <= filt_reg[AI_PEAK];
            end else begin
                deb_cnt_reg <= deb_cnt_reg + 1'b1;
            end
        end
    end

    // ---------------- status ----------------
    logic [7:0] fault_stat;
    logic [7:0] oper_stat;
    logic [7:0] fault_prev_reg;
    logic       peak_prev_reg;
    logic       io_prev_reg;
    logic       blocked;
    logic [6:0] fault_live;

    // blocked taken from the live bits, so no loop through fault_stat
    assign fault_live = {filt_reg[AI_IN_OV], filt_reg[AI_IN_SAG], filt_reg[AI_IN_UV],
                         filt_reg[AI_BAT_OV], filt_reg[AI_BAT_UV], filt_reg[AI_T_CRIT],
                         filt_reg[AI_T_WARN]};
    assign blocked    = |({1'b0, fault_live} & BLOCKING_FAULTS);
    assign fault_stat = {blocked, fault_live};
    assign oper_stat = {5'h00, peak_db_reg, filt_reg[AI_EN_PIN], MODE_ACTIVE};

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            fault_prev_reg <= 8'h00;
            peak_prev_reg  <= 1'b0;
            io_prev_reg    <= 1'b0;
        end else if (CLK_EN) begin
            fault_prev_reg <= fault_stat;
            peak_prev_reg  <= peak_db_reg;
            io_prev_reg    <= io_low;
        end
    end

    // ---------------- serial register access ----------------
    cse_ser_e    ser_state_reg;
    logic [3:0]  bit_cnt_reg;
    logic [7:0]  shift_reg;
    logic        rw_reg;
    logic        expect_addr_reg;
    logic        nack_reg;
    logic [6:0]  ptr_reg;
    logic        wr_stb_reg;
    logic        rd_stb_reg;
    logic [12:0] acc_addr_reg;
    logic [7:0]  wr_data_reg;
    logic        sda_oe_reg;
    logic [7:0]  page_sel_reg;
    logic        scl_prev_reg;
    logic        sda_prev_reg;

    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [12:0] full_addr;

    assign scl        = filt_reg[AI_SCL];
    assign sda        = filt_reg[AI_SDA];
    assign scl_rise   = scl & ~scl_prev_reg;
    assign scl_fall   = ~scl & scl_prev_reg;
    assign start_cond = scl & scl_prev_reg & sda_prev_reg & ~sda;
    assign stop_cond  = scl & scl_prev_reg & ~sda_prev_reg & sda;
    assign full_addr  = {page_sel_reg[PAGE_MSB:0], ptr_reg};

    logic [7:0] fault_evt_reg;
    logic [7:0] sys_evt_reg;
    logic [7:0] fault_mask_reg;
    logic [7:0] sys_mask_reg;
    logic [7:0] sag_thr_reg;
    logic [7:0] bat_low_reg;
    logic [7:0] bat_high_reg;

    function automatic logic [7:0] reg_read(input logic [12:0] a);
        logic [7:0] d;
        d = 8'h00;
        if (a[6:0] == OFS_PAGE_SELECT) begin
            d = page_sel_reg;
        end else begin
            case (a)
                ADR_FAULT_STAT:   d = fault_stat;
                ADR_OPER_STAT:    d = oper_stat;
                ADR_FAULT_EVT:    d = fault_evt_reg;
                ADR_SYS_EVT:      d = sys_evt_reg;
                ADR_FAULT_MASK:   d = fault_mask_reg;
                ADR_SYS_MASK:     d = sys_mask_reg;
                ADR_SAG_THR:      d = sag_thr_reg;
                ADR_BAT_LOW_THR:  d = bat_low_reg;
                ADR_BAT_HIGH_THR: d = bat_high_reg;
                default:          d = 8'h00;
            endcase
        end
        return d;
    endfunction

    // always_comb also follows the registers read inside the function
    logic [7:0] rd_data;
    always_comb begin
        rd_data = reg_read(full_addr);
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            ser_state_reg   <= SER_IDLE;
            bit_cnt_reg     <= 4'h0;
            shift_reg       <= 8'h00;
            rw_reg          <= 1'b0;
            expect_addr_reg <= 1'b1;
            nack_reg        <= 1'b0;
            ptr_reg         <= 7'h00;
            wr_stb_reg      <= 1'b0;
            rd_stb_reg      <= 1'b0;
            acc_addr_reg    <= 13'h0000;
            wr_data_reg     <= 8'h00;
            sda_oe_reg      <= 1'b0;
            scl_prev_reg    <= 1'b1;
            sda_prev_reg    <= 1'b1;
        end else if (CLK_EN) begin
            scl_prev_reg <= scl;
            sda_prev_reg <= sda;
            wr_stb_reg   <= 1'b0;
            rd_stb_reg   <= 1'b0;
            if (io_low) begin
                // serial state held in SER_IDLE with SDA released while the io supply is low
                ser_state_reg <= SER_IDLE;
                sda_oe_reg    <= 1'b0;
            end else if (start_cond) begin
                ser_state_reg <= SER_ADDR;
                bit_cnt_reg   <= 4'h0;
                sda_oe_reg    <= 1'b0;
            end else if (stop_cond) begin
                ser_state_reg <= SER_IDLE;
                sda_oe_reg    <= 1'b0;
            end else begin
                case (ser_state_reg)
                    SER_ADDR, SER_RX: begin
                        if (scl_rise) begin
                            shift_reg   <= {shift_reg[6:0], sda};
                            bit_cnt_reg <= bit_cnt_reg + 1'b1;
                        end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                            if (ser_state_reg == SER_ADDR) begin
                                if (shift_reg[7:1] == SLAVE_ADDR) begin
                                    rw_reg          <= shift_reg[0];
                                    expect_addr_reg <= 1'b1;
                                    sda_oe_reg      <= 1'b1;
                                    ser_state_reg   <= SER_ADDR_ACK;
                                end else begin
                                    ser_state_reg <= SER_IDLE;
                                end
                            end else begin
                                sda_oe_reg    <= 1'b1;
                                ser_state_reg <= SER_RX_ACK;
                                if (expect_addr_reg) begin
                                    ptr_reg         <= shift_reg[6:0];
                                    expect_addr_reg <= 1'b0;
                                end else begin
                                    wr_stb_reg   <= 1'b1;
                                    acc_addr_reg <= full_addr;
                                    wr_data_reg  <= shift_reg;
                                    // paired mode: next byte is an address again
                                    if (page_sel_reg[PAIRED_WRITE_BIT]) begin
                                        expect_addr_reg <= 1'b1;
                                    end else begin
                                        ptr_reg <= ptr_reg + 1'b1;
                                    end
                                end
                            end
                        end
                    end
                    SER_ADDR_ACK, SER_RX_ACK, SER_TX_ACK: begin
                        if (scl_rise) begin
                            nack_reg <= sda;
                        end else if (scl_fall) begin
                            bit_cnt_reg <= 4'h0;
                            if (!rw_reg) begin
                                sda_oe_reg    <= 1'b0;
                                ser_state_reg <= SER_RX;
                            end else if (ser_state_reg == SER_TX_ACK && nack_reg) begin
                                sda_oe_reg    <= 1'b0;
                                ser_state_reg <= SER_IDLE;
                            end else begin
                                shift_reg     <= rd_data;
                                sda_oe_reg    <= ~rd_data[7];
                                rd_stb_reg    <= 1'b1;
                                acc_addr_reg  <= full_addr;
                                ptr_reg       <= ptr_reg + 1'b1;
                                ser_state_reg <= SER_TX;
                            end
                        end
                    end
                    SER_TX: begin
                        if (scl_rise) begin
                            bit_cnt_reg <= bit_cnt_reg + 1'b1;
                        end else if (scl_fall) begin
                            if (bit_cnt_reg == 4'h8) begin
                                sda_oe_reg    <= 1'b0;
                                ser_state_reg <= SER_TX_ACK;
                            end else begin
                                shift_reg  <= {shift_reg[6:0], 1'b0};
                                sda_oe_reg <= ~shift_reg[6];
                            end
                        end
                    end
                    default: begin
                        sda_oe_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ---------------- page select ----------------
    logic page_wr;
    assign page_wr = wr_stb_reg && acc_addr_reg[6:0] == OFS_PAGE_SELECT;

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            page_sel_reg <= RST_PAGE_SELECT;
        end else if (CLK_EN) begin
            if (page_wr) begin
                page_sel_reg <= wr_data_reg;
            end else if ((wr_stb_reg || rd_stb_reg) && page_sel_reg[PAGE_RETURN_BIT]
                         && acc_addr_reg[6:0] != OFS_PAGE_SELECT) begin
                page_sel_reg[PAGE_MSB:0] <= '0;
            end
        end
    end

    // ---------------- masks and thresholds ----------------
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            fault_mask_reg <= RST_MASK;
            sys_mask_reg   <= RST_MASK;
            sag_thr_reg    <= RST_THRESHOLD;
            bat_low_reg    <= RST_THRESHOLD;
            bat_high_reg   <= RST_THRESHOLD;
        end else if (CLK_EN && wr_stb_reg) begin
            case (acc_addr_reg)
                ADR_FAULT_MASK:   fault_mask_reg <= wr_data_reg;
                ADR_SYS_MASK:     sys_mask_reg   <= wr_data_reg & SYS_EVT_USED;
                ADR_SAG_THR:      sag_thr_reg    <= wr_data_reg;
                ADR_BAT_LOW_THR:  bat_low_reg    <= {2'b00, wr_data_reg[BAT_CODE_W-1:0]};
                ADR_BAT_HIGH_THR: bat_high_reg   <= {2'b00, wr_data_reg[BAT_CODE_W-1:0]};
                default: begin
                end
            endcase
        end
    end

    // ---------------- events ----------------
    logic [7:0] fault_set;
    logic [7:0] sys_set;
    logic [7:0] fault_clr;
    logic [7:0] sys_clr;

    always_comb begin
        fault_set = 8'h00;
        fault_set[FB_EN_BLOCK] = ENABLE_REQUEST & blocked;
        // rising edges only, so a held fault fires once
        fault_set[6:2] = fault_stat[6:2] & ~fault_prev_reg[6:2];
        fault_set[FB_T_CRIT] = fault_stat[FB_T_CRIT] & ~fault_prev_reg[FB_T_CRIT];
        fault_set[FB_T_WARN] = fault_stat[FB_T_WARN] & ~fault_prev_reg[FB_T_WARN];
        sys_set = 8'h00;
        sys_set[EB_T_RESET]  = THERMAL_RESET_ENTRY;
        sys_set[EB_IO_LOW]   = io_low & ~io_prev_reg;
        sys_set[EB_TIMER]    = TIMER_EXPIRED;
        sys_set[EB_PEAK_CUR] = peak_db_reg & ~peak_prev_reg;
        sys_set[EB_READY]    = READY_ENTRY & ~io_low;
    end

    assign fault_clr = (wr_stb_reg && acc_addr_reg == ADR_FAULT_EVT) ? wr_data_reg : 8'h00;
    assign sys_clr   = (wr_stb_reg && acc_addr_reg == ADR_SYS_EVT) ?
                       (wr_data_reg & ~(8'h01 << EB_T_RESET)) : 8'h00;

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            fault_evt_reg <= RST_EVENTS;
            sys_evt_reg   <= RST_EVENTS;
        end else if (CLK_EN) begin
            // a set in the clearing cycle wins
            fault_evt_reg <= (fault_evt_reg & ~fault_clr) | fault_set;
            sys_evt_reg   <= ((sys_evt_reg & ~sys_clr) | sys_set) & SYS_EVT_USED;
            if (POWER_ON_ENTRY && !THERMAL_RESET_ENTRY) begin
                sys_evt_reg[EB_T_RESET] <= 1'b0;
            end
        end
    end

    // ---------------- outputs ----------------
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            IRQ                   <= 1'b0;
            EN_BLOCKED            <= 1'b0;
            SDA_OUT               <= 1'b0;
            SDA_OE                <= 1'b0;
            SAG_THRESHOLD_MV      <= 16'h0000;
            BAT_LOW_THRESHOLD_MV  <= 16'h0000;
            BAT_HIGH_THRESHOLD_MV <= 16'h0000;
        end else if (CLK_EN) begin
            IRQ <= |(fault_evt_reg & ~fault_mask_reg) | |(sys_evt_reg & ~sys_mask_reg);
            EN_BLOCKED            <= blocked;
            SDA_OUT               <= 1'b0;
            SDA_OE                <= sda_oe_reg;
            SAG_THRESHOLD_MV      <= sag_mv(sag_thr_reg);
            BAT_LOW_THRESHOLD_MV  <= bat_mv(BAT_LOW_BASE_MV, bat_low_reg);
            BAT_HIGH_THRESHOLD_MV <= bat_mv(BAT_HIGH_BASE_MV, bat_high_reg);
        end
    end

endmodule

`default_nettype wire

// *** core/cse_pkg.sv ***
`default_nettype none

package cse_pkg;

    // register map, full 13-bit address = {page[5:0], offset[6:0]}
    localparam int          ADDR_W          = 13;
    localparam logic [6:0]  OFS_PAGE_SELECT = 7'h00;
    localparam logic [12:0] ADR_FAULT_STAT  = 13'h0001;
    localparam logic [12:0] ADR_OPER_STAT   = 13'h0002;
    localparam logic [12:0] ADR_FAULT_EVT   = 13'h0003;
    localparam logic [12:0] ADR_SYS_EVT     = 13'h0004;
    localparam logic [12:0] ADR_FAULT_MASK  = 13'h0005;
    localparam logic [12:0] ADR_SYS_MASK    = 13'h0006;
    localparam logic [12:0] ADR_SAG_THR     = 13'h0007;
    localparam logic [12:0] ADR_BAT_LOW_THR = 13'h0008;
    localparam logic [12:0] ADR_BAT_HIGH_THR = 13'h0009;

    // page_select_control fields
    localparam int PAGE_RETURN_BIT  = 7;
    localparam int PAIRED_WRITE_BIT = 6;
    localparam int PAGE_MSB         = 5;

    // fault_status / fault_events / fault_irq_masks bit positions
    localparam int FB_EN_BLOCK  = 7;
    localparam int FB_IN_OV     = 6;
    localparam int FB_IN_SAG    = 5;
    localparam int FB_IN_UV     = 4;
    localparam int FB_BAT_OV    = 3;
    localparam int FB_BAT_UV    = 2;
    localparam int FB_T_CRIT    = 1;
    localparam int FB_T_WARN    = 0;
    // faults that keep the buck from being enabled
    localparam logic [7:0] BLOCKING_FAULTS = 8'h5E;

    // operating_status / system_events bit positions
    localparam int SB_PEAK_CUR  = 2;
    localparam int SB_EN_PIN    = 1;
    localparam int SB_MODE      = 0;
    localparam int EB_T_RESET   = 4;
    localparam int EB_IO_LOW    = 3;
    localparam int EB_TIMER     = 2;
    localparam int EB_PEAK_CUR  = 1;
    localparam int EB_READY     = 0;
    localparam logic [7:0] SYS_EVT_USED = 8'h1F;

    // reset values
    localparam logic [7:0] RST_PAGE_SELECT = 8'h00;
    localparam logic [7:0] RST_MASK        = 8'h00;
    localparam logic [7:0] RST_THRESHOLD   = 8'h00;
    localparam logic [7:0] RST_EVENTS      = 8'h00;

    // threshold coding, millivolts
    localparam logic [7:0] SAG_CODE_MAX   = 8'h3B;
    localparam int         BAT_LOW_BASE_MV  = 2000;
    localparam int         BAT_HIGH_BASE_MV = 3600;
    localparam int         BAT_STEP_MV      = 25;
    localparam int         BAT_CODE_W       = 6;

    // async input synchroniser slots
    localparam int AI_IN_OV   = 0;
    localparam int AI_IN_SAG  = 1;
    localparam int AI_IN_UV   = 2;
    localparam int AI_BAT_OV  = 3;
    localparam int AI_BAT_UV  = 4;
    localparam int AI_T_CRIT  = 5;
    localparam int AI_T_WARN  = 6;
    localparam int AI_PEAK    = 7;
    localparam int AI_EN_PIN  = 8;
    localparam int AI_IO_LOW  = 9;
    localparam int AI_SCL     = 10;
    localparam int AI_SDA     = 11;
    localparam int AI_COUNT   = 12;
    // serial lines rest high: no false edge right after reset
    localparam logic [AI_COUNT-1:0] SYNC_RST = 12'hC00;

    // peak current debounce
    localparam int CLK_PERIOD_NS   = 10;
    localparam int DEBOUNCE_NS     = 1000;
    localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_W           = 7;

    // serial slave address, arbitrary value
    localparam logic [6:0] SLAVE_ADDR = 7'h2A;

    typedef enum logic [2:0] {
        SER_IDLE,
        SER_ADDR,
        SER_ADDR_ACK,
        SER_RX,
        SER_RX_ACK,
        SER_TX,
        SER_TX_ACK
    } cse_ser_e;

endpackage

`default_nettype wire

// *** test/cse_regs_props.sv ***
`default_nettype none
module cse_regs_props (
    input wire logic        CORE_CLK,
    input wire logic        RESET,
    input wire logic        SCL_IN,
    input wire logic        SDA_OE,
    input wire logic        INPUT_OVERVOLT_CMP,
    input wire logic        IRQ,
    input wire logic        EN_BLOCKED,
    input wire logic [15:0] SAG_THRESHOLD_MV,
    input wire logic [15:0] BAT_LOW_THRESHOLD_MV,
    input wire logic [15:0] BAT_HIGH_THRESHOLD_MV
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);
    // long enough to cover the pin synchroniser, the filter stage and the EN_BLOCKED output register
    sequence s_ov_held;
        INPUT_OVERVOLT_CMP [*8];
    endsequence
    a_ov_blocks_enable: assert property (s_ov_held |-> EN_BLOCKED)
        else $error("enable not blocked");
    a_irq_quiet_start: assert property ($fell(RESET) |-> !IRQ [*3])
        else $error("irq after reset");
    a_oe_steady_high: assert property (SCL_IN [*8] |-> $stable(SDA_OE))
        else $error("sda moved while scl high");
    a_sag_range: assert property (!$past(RESET) |-> SAG_THRESHOLD_MV inside {[4300:12000]})
        else $error("sag threshold out of range");
    a_low_range: assert property (!$past(RESET) |-> BAT_LOW_THRESHOLD_MV inside {[2000:3575]})
        else $error("low threshold out of range");
    a_high_range: assert property (!$past(RESET) |-> BAT_HIGH_THRESHOLD_MV inside {[3600:5175]})
        else $error("high threshold out of range");
    a_sag_write_time: assert property (!$past(RESET, 2) && $changed(SAG_THRESHOLD_MV) |-> !SCL_IN)
        else $error("sag changed outside a write");
    a_low_write_time: assert property (!$past(RESET, 2) && $changed(BAT_LOW_THRESHOLD_MV) |-> !SCL_IN)
        else $error("low changed outside a write");
endmodule
bind cse_regs cse_regs_props u_props (.*);
`default_nettype wire

// *** test/cse_host.sv ***
`default_nettype none
module cse_host (
    input  wire logic clk,
    input  wire logic oe,
    output logic      scl,
    output wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    logic low = 1'b0;
    // pull-up: a released line reads high
    assign sda = !(low || oe);
    initial scl = 1'b1;
    // data moves 5 cycles after scl so no false start or stop is seen
    task automatic ph(input logic l, input logic s);
        scl = s;
        repeat (5) @(negedge clk);
        low = l;
        repeat (15) @(negedge clk);
    endtask
    task automatic bt(input logic b, output logic r);
        ph(!b, 1'b0);
        ph(!b, 1'b1);
        r = sda;
    endtask
    // 0x55 opens the read phase with a repeated start
    task automatic tr(input logic [7:0] q[$], output logic [7:0] d);
        logic r;
        foreach (q[i]) begin
            if (i == 0 || q[i] == 8'h55) begin
                ph(1'b0, 1'b0);
                ph(1'b0, 1'b1);
                ph(1'b1, 1'b1);
            end
            for (int k = 7; k >= 0; k--) bt(q[i][k], r);
            bt(1'b1, r);
        end
        if (q[$] == 8'h55) begin
            for (int k = 7; k >= 0; k--) bt(1'b1, d[k]);
            bt(1'b1, r);
        end
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
        ph(1'b0, 1'b1);
    endtask
endmodule
`default_nettype wire

// *** test/test_charger_status_event_regs.sv ***
`default_nettype none
module test_charger_status_event_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic CORE_CLK = 0, RESET = 1, CLK_EN = 1, ENABLE_PIN = 0, IO_SUPPLY_LOW = 0;
    logic MODE_ACTIVE = 0, PEAK_CURRENT_CMP = 0, INPUT_SAG_CMP = 0, THERMAL_WARNING_CMP = 0;
    logic INPUT_OVERVOLT_CMP = 0, INPUT_UNDERVOLT_CMP = 0, BATTERY_OVERVOLT_CMP = 0;
    logic BATTERY_UNDERVOLT_CMP = 0, THERMAL_CRITICAL_CMP = 0, ENABLE_REQUEST = 0;
    logic TIMER_EXPIRED = 0, THERMAL_RESET_ENTRY = 0, POWER_ON_ENTRY = 0, READY_ENTRY = 0;
    wire SCL_IN, SDA_IN, SDA_OUT, SDA_OE, IRQ, EN_BLOCKED;
    wire [15:0] SAG_THRESHOLD_MV, BAT_LOW_THRESHOLD_MV, BAT_HIGH_THRESHOLD_MV;
    int failures = 0, cmp_count = 0, cyc = 0;
    logic [7:0] d;
    cse_regs DUT (.*);
    cse_host host (.clk(CORE_CLK), .oe(SDA_OE), .scl(SCL_IN), .sda(SDA_IN));
    initial forever #5 CORE_CLK = !CORE_CLK;
    always @(posedge CORE_CLK) if (++cyc == 60000) give_verdict(1);
    task automatic give_verdict(input int f);
        failures += f;
        $display("checks %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] s, e);
        cmp_count++;
        if (s !== e) failures++;
        if (s !== e) $display("wrong value %s expected %h seen %h", n, e, s);
    endtask
    task automatic wr(input logic [7:0] q[$]);
        host.tr({8'h54, q}, d);
    endtask
    task automatic rd(input logic [7:0] a, e);
        host.tr({8'h54, a, 8'h55}, d);
        chk("read", d, e);
    endtask
    task automatic pulse(ref logic p);
        p = 1;
        @(negedge CORE_CLK);
        p = 0;
    endtask
    task automatic t_thr();
        wr('{8'h07, 8'hFF, 8'h04, 8'hC5});
        chk("sag", SAG_THRESHOLD_MV, 16'd12000);
        chk("low", BAT_LOW_THRESHOLD_MV, 16'd2100);
        chk("high", BAT_HIGH_THRESHOLD_MV, 16'd3725);
        rd(8'h07, 8'hFF);
        wr('{8'h00, 8'h40});
        wr('{8'h07, 8'h10, 8'h05, 8'hA5});
        chk("sag", SAG_THRESHOLD_MV, 16'd5400);
        wr('{8'h00, 8'h00});
        rd(8'h05, 8'hA5);
    endtask
    task automatic t_page();
        wr('{8'h00, 8'h01});
        rd(8'h05, 8'h00);
        rd(8'h05, 8'h00);
        wr('{8'h00, 8'h81});
        rd(8'h05, 8'h00);
        rd(8'h05, 8'hA5);
    endtask
    task automatic t_evt();
        INPUT_OVERVOLT_CMP = 1;
        repeat (10) @(negedge CORE_CLK);
        chk("blk", EN_BLOCKED, 1);
        chk("irq", IRQ, 1);
        pulse(ENABLE_REQUEST);
        rd(8'h01, 8'hC0);
        INPUT_OVERVOLT_CMP = 0;
        THERMAL_WARNING_CMP = 1;
        wr('{8'h03, 8'h00});
        rd(8'h03, 8'hC1);
        wr('{8'h03, 8'hC1});
        THERMAL_WARNING_CMP = 0;
        rd(8'h03, 8'h00);
        pulse(TIMER_EXPIRED);
        pulse(THERMAL_RESET_ENTRY);
        rd(8'h04, 8'h14);
        wr('{8'h04, 8'hFF});
        rd(8'h04, 8'h10);
        pulse(POWER_ON_ENTRY);
        rd(8'h04, 8'h00);
        chk("irq", IRQ, 0);
    endtask
    task automatic t_sys();
        ENABLE_PIN = 1;
        MODE_ACTIVE = 1;
        PEAK_CURRENT_CMP = 1;
        repeat (50) @(negedge CORE_CLK);
        chk("irq", IRQ, 0);
        repeat (70) @(negedge CORE_CLK);
        chk("irq", IRQ, 1);
        rd(8'h02, 8'h07);
        BATTERY_OVERVOLT_CMP = 1;
        THERMAL_CRITICAL_CMP = 1;
        IO_SUPPLY_LOW = 1;
        repeat (10) @(negedge CORE_CLK);
        pulse(READY_ENTRY);
        IO_SUPPLY_LOW = 0;
        rd(8'h03, 8'h0A);
        rd(8'h04, 8'h0A);
        pulse(READY_ENTRY);
        rd(8'h04, 8'h0B);
    endtask
    initial begin
        repeat (6) @(negedge CORE_CLK);
        RESET = 0;
        repeat (6) @(negedge CORE_CLK);
        chk("sag", SAG_THRESHOLD_MV, 16'd4300);
        chk("sda out", SDA_OUT, 0);
        t_thr();
        t_page();
        t_evt();
        t_sys();
        give_verdict(0);
    end
endmodule
`default_nettype wire
